// [core/rfcirq_pkg.sv]
package rfcirq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam int AXI_ADDR_W = 20;
	localparam logic [17:0] IDX_TB_LOW = 18'h053a8;
	localparam logic [17:0] IDX_TB_HIGH = 18'h053aa;
	localparam logic [17:0] IDX_IE = 18'h053ac;
	localparam logic [17:0] IDX_FLAGS = 18'h053ae;

	////////////////////////////////////////////////////////////////////////////
	// field layout, shared by enable and flag registers
	localparam int NUM_CAUSES = 5;
	localparam int BIT_REF_DONE = 0;
	localparam int BIT_SENSOR_A_DONE = 1;
	localparam int BIT_SENSOR_B_DONE = 2;
	localparam int BIT_MEAS_OVF = 3;
	localparam int BIT_TB_OVF = 4;
	localparam int TB_WIDTH = 24;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [23:0] RST_TB_COUNT = 24'h000000;
	localparam logic [4:0] RST_IE = 5'h00;
	localparam logic [4:0] RST_FLAGS = 5'h00;

	////////////////////////////////////////////////////////////////////////////
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_TB_LOW,
		SEL_TB_HIGH,
		SEL_IE,
		SEL_FLAGS
	} rfcirq_sel_t;

endpackage : rfcirq_pkg

// [core/rfcirq_timebase.sv]
`timescale 1ns/10ps
module rfcirq_timebase
	import rfcirq_pkg::*;
#(
	parameter int WIDTH = TB_WIDTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// count control
	input wire logic tick_i,
	input wire logic [2:0] load_byte_i,
	input wire logic [WIDTH-1:0] load_data_i,
	// state
	output logic [WIDTH-1:0] count_o,
	output logic ovf_o
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic ovf;
	} rfcirq_tb_state_t;

	rfcirq_tb_state_t r;
	rfcirq_tb_state_t n;

	////////////////////////////////////////////////////////////////////////////
	// a write to any byte overrides the tick in that cycle, so software
	// never races a half-updated count
	always_comb begin
		n = r;
		n.ovf = 1'b0;
		if (|load_byte_i) begin
			for (int b = 0; b < 3; b++) begin
				if (load_byte_i[b]) begin
					n.count[b*8 +: 8] = load_data_i[b*8 +: 8];
				end
			end
		end else if (tick_i) begin
			n.count = r.count + WIDTH'(1);
			n.ovf = &r.count;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r.count <= RST_TB_COUNT[WIDTH-1:0];
			r.ovf <= 1'b0;
		end else begin
			r <= n;
		end
	end

	assign count_o = r.count;
	assign ovf_o = r.ovf;

	tb_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(tick_i && load_byte_i == 3'h0 && &count_o) |=> (ovf_o && count_o == '0))
		else $error("time base wrap did not raise overflow");

endmodule : rfcirq_timebase

// [core/rfcirq_top.sv]
`timescale 1ns/10ps
module rfcirq_top
	import rfcirq_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// axi4-lite write address
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic [2:0] s_axi_awprot_i,
	// axi4-lite write data
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	// axi4-lite write response
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	// axi4-lite read address
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic [2:0] s_axi_arprot_i,
	// axi4-lite read data
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	// converter events, same clock
	input wire logic tb_tick_i,
	input wire logic meas_ovf_i,
	input wire logic sensor_b_done_i,
	input wire logic sensor_a_done_i,
	input wire logic ref_done_i,
	// interrupt
	output logic irq_o
);

	typedef struct packed {
		logic aw_rdy;
		logic aw_held;
		logic [AXI_ADDR_W-1:0] aw_addr;
		logic w_rdy;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		rfcirq_sel_t rsel;
		logic [NUM_CAUSES-1:0] ie;
		logic [NUM_CAUSES-1:0] flags;
		logic irq;
	} rfcirq_state_t;

	rfcirq_state_t r;
	rfcirq_state_t n;

	logic wr_fire;
	rfcirq_sel_t wsel;
	rfcirq_sel_t rsel_in;
	logic [2:0] tb_load;
	logic [NUM_CAUSES-1:0] flag_set;
	logic [NUM_CAUSES-1:0] flag_clr;
	logic [TB_WIDTH-1:0] tb_count;
	logic tb_ovf;

	// word index compare; the two byte-offset bits of the address are ignored
	function automatic rfcirq_sel_t decode(input logic [AXI_ADDR_W-1:0] addr);
		rfcirq_sel_t s;
		s = SEL_NONE;
		case (addr[AXI_ADDR_W-1:2])
			IDX_TB_LOW: s = SEL_TB_LOW;
			IDX_TB_HIGH: s = SEL_TB_HIGH;
			IDX_IE: s = SEL_IE;
			IDX_FLAGS: s = SEL_FLAGS;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction : decode

	////////////////////////////////////////////////////////////////////////////
	// time base counter
	rfcirq_timebase #(
		.WIDTH(TB_WIDTH)
	) rfcirq_timebase_i (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tb_tick_i),
		.load_byte_i(tb_load),
		// the high register carries count bits 23..16 on byte lane 0
		.load_data_i({r.w_data[7:0], r.w_data[15:0]}),
		.count_o(tb_count),
		.ovf_o(tb_ovf)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		n = r;
		wsel = decode(r.aw_addr);
		rsel_in = decode(s_axi_araddr_i);
		wr_fire = r.aw_held && r.w_held && !r.bvalid;
		tb_load = 3'h0;
		flag_clr = '0;
		flag_set = '0;

		// write channels are taken independently, in either order
		if (s_axi_awvalid_i && r.aw_rdy) begin
			n.aw_held = 1'b1;
			n.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && r.w_rdy) begin
			n.w_held = 1'b1;
			n.w_data = s_axi_wdata_i;
			n.w_strb = s_axi_wstrb_i;
		end
		if (r.bvalid && s_axi_bready_i) begin
			n.bvalid = 1'b0;
		end
		if (wr_fire) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end

		// register writes
		if (wr_fire) begin
			case (wsel)
				SEL_TB_LOW: tb_load[1:0] = r.w_strb[1:0];
				SEL_TB_HIGH: tb_load[2] = r.w_strb[0];
				SEL_IE: begin
					if (r.w_strb[0]) begin
						n.ie = r.w_data[NUM_CAUSES-1:0];
					end
				end
				SEL_FLAGS: begin
					if (r.w_strb[0]) begin
						flag_clr = r.w_data[NUM_CAUSES-1:0];
					end
				end
				default: tb_load = 3'h0;
			endcase
		end

		// a cause arriving with its clear is kept: set wins
		flag_set[BIT_TB_OVF] = tb_ovf;
		flag_set[BIT_MEAS_OVF] = meas_ovf_i;
		flag_set[BIT_SENSOR_B_DONE] = sensor_b_done_i;
		flag_set[BIT_SENSOR_A_DONE] = sensor_a_done_i;
		flag_set[BIT_REF_DONE] = ref_done_i;
		n.flags = (r.flags & ~flag_clr) | flag_set;
		n.irq = |(n.flags & n.ie);

		// reads
		if (r.rvalid && s_axi_rready_i) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && r.ar_rdy) begin
			n.rvalid = 1'b1;
			n.rsel = rsel_in;
			n.rresp = RESP_OKAY;
			n.rdata = 32'h00000000;
			case (rsel_in)
				SEL_TB_LOW: n.rdata[15:0] = tb_count[15:0];
				SEL_TB_HIGH: n.rdata[7:0] = tb_count[23:16];
				SEL_IE: n.rdata[NUM_CAUSES-1:0] = r.ie;
				SEL_FLAGS: n.rdata[NUM_CAUSES-1:0] = r.flags;
				default: n.rresp = RESP_SLVERR;
			endcase
		end

		// readies registered so every bus output comes from a flop
		n.aw_rdy = !n.aw_held;
		n.w_rdy = !n.w_held;
		n.ar_rdy = !n.rvalid;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.ie <= RST_IE;
			r.flags <= RST_FLAGS;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign s_axi_awready_o = r.aw_rdy;
	assign s_axi_wready_o = r.w_rdy;
	assign s_axi_bvalid_o = r.bvalid;
	assign s_axi_bresp_o = r.bresp;
	assign s_axi_arready_o = r.ar_rdy;
	assign s_axi_rvalid_o = r.rvalid;
	assign s_axi_rdata_o = r.rdata;
	assign s_axi_rresp_o = r.rresp;
	assign irq_o = r.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence wr_commit_s;
		r.aw_held && r.w_held && !r.bvalid;
	endsequence

	sequence flags_write_s;
		wr_commit_s ##0 (wsel == SEL_FLAGS && r.w_strb[0]);
	endsequence

	sequence bresp_s;
		s_axi_bvalid_o [*1];
	endsequence

	write_answer_a: assert property (wr_commit_s |=> bresp_s)
		else $error("committed write gave no response");

	tbh_upper_zero_a: assert property (
		(s_axi_rvalid_o && r.rsel == SEL_TB_HIGH) |-> s_axi_rdata_o[31:8] == 24'h000000)
		else $error("time base high upper bits not zero");

	tbl_write_a: assert property (
		(wr_commit_s ##0 (wsel == SEL_TB_LOW && r.w_strb[1:0] == 2'h3 && !tb_tick_i))
		|=> tb_count[15:0] == $past(r.w_data[15:0]))
		else $error("time base low write not taken");

	irq_gate_a: assert property (
		(r.flags != 5'h00 && r.ie == 5'h00) [*2] |-> !irq_o)
		else $error("interrupt raised with all causes disabled");

	tb_flag_a: assert property (tb_ovf |=> r.flags[BIT_TB_OVF])
		else $error("time base overflow flag not set");

	w1c_clear_a: assert property (
		(flags_write_s ##0 (r.w_data[BIT_MEAS_OVF] && !meas_ovf_i)) |=> !r.flags[BIT_MEAS_OVF])
		else $error("write one did not clear flag");

	meas_sticky_a: assert property (
		(r.flags[BIT_MEAS_OVF] && !(wr_fire && wsel == SEL_FLAGS && r.w_strb[0] && r.w_data[BIT_MEAS_OVF]))
		|=> r.flags[BIT_MEAS_OVF])
		else $error("measurement overflow flag dropped");

	done_flags_a: assert property (
		(ref_done_i || sensor_a_done_i) |=>
		(r.flags[BIT_REF_DONE] || !$past(ref_done_i)) && (r.flags[BIT_SENSOR_A_DONE] || !$past(sensor_a_done_i)))
		else $error("completion flag not set");

	senb_pos_a: assert property (
		(sensor_b_done_i && r.ie[BIT_SENSOR_B_DONE]) |=> irq_o)
		else $error("sensor b done not routed through bit 2");

	zero_keep_a: assert property (
		flags_write_s |=> (r.flags & ~$past(r.w_data[4:0])) == ($past(r.flags) & ~$past(r.w_data[4:0]))
		|| $past(|flag_set))
		else $error("zero write disturbed a flag");

	////////////////////////////////////////////////////////////////////////////
	// register landing and bus answers
	sequence rd_take_s;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence

	rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid_o)
		else $error("accepted read gave no data");

	tbh_write_a: assert property (
		(wr_commit_s ##0 (wsel == SEL_TB_HIGH && r.w_strb[0])) |=> tb_count[23:16] == $past(r.w_data[7:0]))
		else $error("time base high write not taken");

	ie_write_a: assert property (
		(wr_commit_s ##0 (wsel == SEL_IE && r.w_strb[0])) |=> r.ie == $past(r.w_data[NUM_CAUSES-1:0]))
		else $error("enable write not taken");

	meas_flag_a: assert property (meas_ovf_i |=> r.flags[BIT_MEAS_OVF])
		else $error("measurement overflow flag not set");

	senb_flag_a: assert property (sensor_b_done_i |=> r.flags[BIT_SENSOR_B_DONE])
		else $error("sensor b done flag not at bit 2");

	regs_upper_a: assert property (
		(s_axi_rvalid_o && (r.rsel == SEL_IE || r.rsel == SEL_FLAGS)) |-> s_axi_rdata_o[31:NUM_CAUSES] == 27'h0000000)
		else $error("reserved enable or flag bits not zero");

	bad_read_a: assert property (
		(s_axi_rvalid_o && r.rsel == SEL_NONE) |-> (s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h00000000))
		else $error("unmapped read not refused");

	bad_write_a: assert property (
		(wr_commit_s ##0 (wsel == SEL_NONE)) |=> (s_axi_bresp_o == RESP_SLVERR && $stable(r.ie)))
		else $error("unmapped write not refused");

endmodule : rfcirq_top

// [test/rfcirq_bench.sv]
`timescale 1ns/10ps
module rfcirq_bench
	import rfcirq_pkg::*;
;
	////////////////////////////////////////////////////////////////////////////
	localparam logic [19:0] A_LOW = {IDX_TB_LOW, 2'h0};
	localparam logic [19:0] A_HIGH = {IDX_TB_HIGH, 2'h0};
	localparam logic [19:0] A_IE = {IDX_IE, 2'h0};
	localparam logic [19:0] A_FLG = {IDX_FLAGS, 2'h0};
	localparam logic [19:0] A_BAD = 20'h00010;
	logic clk_i, rst_n_i;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [19:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [4:0] ev, m;
	int err_total, check_count, seed, cyc;

	rfcirq_top rfcirq_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.tb_tick_i(ev[4]), .meas_ovf_i(ev[3]), .sensor_b_done_i(ev[2]), .sensor_a_done_i(ev[1]),
		.ref_done_i(ev[0]), .irq_o(irq));

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic wrap_up;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	function automatic logic [31:0] exp_irq(input logic [4:0] flg, input logic [4:0] msk);
		return {31'h0, |(flg & msk)};
	endfunction : exp_irq

	// handshakes judged on the values the design sampled at the same rising edge
	task automatic axi_wr(input logic [19:0] a, input logic [31:0] dat, output logic [1:0] r);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (pa | pw) begin
			@(posedge clk_i);
			if (pa & awready) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw & wready) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge clk_i); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	// rready raised only after the address is taken, so back-to-back reads never touch it twice
	task automatic axi_rd(input logic [19:0] a, output logic [31:0] dat, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk_i); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk_i); while (!rvalid);
		dat = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic pulse(input int k);
		ev <= 5'h01 << k;
		@(posedge clk_i) ev <= 5'h00;
		@(posedge clk_i);
	endtask : pulse

	task automatic run_tests;
		axi_rd(A_LOW, rd, rs);
		chk(rd, 32'h00000000);
		axi_rd(A_HIGH, rd, rs);
		chk(rd, 32'h00000000);
		axi_rd(A_IE, rd, rs);
		chk(rd, 32'h00000000);
		axi_rd(A_FLG, rd, rs);
		chk(rd, 32'h00000000);
		for (int k = 0; k < 4; k++) begin
			d = $random(seed);
			if (k == 0) d = 32'hffffffff;
			axi_wr(A_IE, d, rs);
			axi_rd(A_IE, rd, rs);
			chk(rd, {27'h0, d[4:0]});
			axi_wr(A_HIGH, d, rs);
			axi_rd(A_HIGH, rd, rs);
			chk(rd, {24'h0, d[7:0]});
			axi_wr(A_LOW, d, rs);
			axi_rd(A_LOW, rd, rs);
			chk(rd, {16'h0, d[15:0]});
		end
		// unmapped place answers with an error and reads zero
		axi_rd(A_BAD, rd, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		chk(rd, 32'h00000000);
		axi_wr(A_BAD, 32'hffffffff, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		for (int k = 0; k < 4; k++) begin
			m = (k == 0) ? 5'h00 : 5'($random(seed));
			axi_wr(A_IE, {27'h0, m}, rs);
			axi_wr(A_FLG, 32'h0000001f, rs);
			pulse(k);
			axi_rd(A_FLG, rd, rs);
			chk(rd, 32'h1 << k);
			chk({31'h0, irq}, exp_irq(5'h01 << k, m));
			axi_wr(A_FLG, 32'h00000000, rs);
			axi_rd(A_FLG, rd, rs);
			chk(rd, 32'h1 << k);
			axi_wr(A_FLG, 32'h1 << k, rs);
			axi_rd(A_FLG, rd, rs);
			chk(rd, 32'h00000000);
			chk({31'h0, irq}, 32'h00000000);
		end
		// count at all ones, one tick wraps it and raises the overflow flag
		axi_wr(A_IE, 32'h00000010, rs);
		axi_wr(A_LOW, 32'h0000ffff, rs);
		axi_wr(A_HIGH, 32'h000000ff, rs);
		pulse(4);
		repeat (4) @(posedge clk_i);
		axi_rd(A_FLG, rd, rs);
		chk(rd, 32'h00000010);
		chk({31'h0, irq}, exp_irq(5'h10, 5'h10));
		axi_rd(A_LOW, rd, rs);
		chk(rd, 32'h00000000);
		axi_rd(A_HIGH, rd, rs);
		chk(rd, 32'h00000000);
		axi_wr(A_FLG, 32'h00000010, rs);
		axi_rd(A_FLG, rd, rs);
		chk(rd, 32'h00000000);
	endtask : run_tests

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 20'h00000;
		araddr = 20'h00000;
		wdata = 32'h00000000;
		wstrb = 4'hf;
		ev = 5'h00;
		err_total = 0;
		check_count = 0;
		cyc = 0;
		seed = 72;
		rst_n_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		// hang guard, well above the roughly 180 cycles the sequence needs
		fork
			run_tests();
			begin
				while (cyc < 20000) begin
					@(posedge clk_i);
					cyc++;
				end
				err_total++;
			end
		join_any
		wrap_up();
	end
endmodule : rfcirq_bench
